// [core/mars_silo.sv]
// Chosen here: the register offsets and the plain strobed port.
module mars_silo
  import mars_pkg::*;
#(
  parameter int LINES = 8,
  parameter longint CLK_HZ = 200_000_000
)
(
  // Clock and control
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  // Serial lines and modem pins
  input wire logic [LINES-1:0] rx_pin,
  input wire logic [LINES-1:0] cd_pin,
  input wire logic [LINES-1:0] ri_pin,
  input wire logic loop_jumper_pin,
  output logic [LINES-1:0] dtr_pin,
  // Interrupt
  output logic irq
);
  localparam int SW = 3 * LINES + 1;
  localparam int JMP = 3 * LINES;

  typedef struct packed {
    logic [SW-1:0] s1;
    logic [SW-1:0] s2;
    logic [SW-1:0] s3;
    logic [SW-1:0] filt;
    mars_entry_t [SILO_DEPTH-1:0] silo;
    logic [5:0] wptr;
    logic [5:0] rptr;
    logic [6:0] count;
    logic alarm;
    logic ovr_pend;
    logic clr;
    logic receive_interrupt_enable;
    logic silo_alarm_enable;
    logic [LINES-1:0][LP_W-1:0] lp;
    logic [LINES-1:0] dtr;
    logic [1:0] stat;
    logic [1:0] mask;
    logic irq;
    logic [31:0] rd_data;
  } mars_top_state_t;

  mars_top_state_t r, n;
  logic [LINES-1:0] rdy;
  logic [LINES-1:0] rxon;
  logic [LINES-1:0] take;
  logic [LINES-1:0][7:0] ch_data;
  logic [LINES-1:0] ch_frm;
  logic [LINES-1:0] ch_par;
  logic [LINES-1:0] car;
  logic [LINES-1:0] ring;
  logic [SW-1:0] agree;
  logic [2:0] sel;
  logic found;
  logic store;
  logic ovr;
  logic pop;
  logic jumper;

  // ----------------------------------------
  // Line receivers
  // ----------------------------------------
  // All lines run side by side with their own parameter words
  for (genvar g = 0; g < LINES; g++)
  begin : g_line
    mars_line_if lif();
    assign lif.rx_level = r.filt[g];
    assign lif.param = r.lp[g];
    assign lif.take = take[g];
    assign rdy[g] = lif.ready;
    assign ch_data[g] = lif.data;
    assign ch_frm[g] = lif.frm_err;
    assign ch_par[g] = lif.parity_error_flag;
    assign rxon[g] = r.lp[g][LP_W-1];
    mars_line_rx #(
      .CLK_HZ(CLK_HZ)
    ) u_rx (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .lif(lif.rx)
    );
  end

  // ----------------------------------------
  // Pin conditioning and modem view
  // ----------------------------------------
  // A level counts once the second and third stages agree
  assign agree = ~(r.s2 ^ r.s3);
  assign jumper = r.filt[JMP];
  assign car = jumper ? r.dtr : r.filt[2*LINES-1:LINES];
  assign ring = jumper ? r.dtr : r.filt[3*LINES-1:2*LINES];

  // ----------------------------------------
  // Line arbitration
  // ----------------------------------------
  // Lowest ready line wins; a character lasts far longer than one scan
  always_comb
  begin
    found = 1'b0;
    sel = 3'h0;
    for (int i = LINES - 1; i >= 0; i--)
    begin
      if (rdy[i] && rxon[i])
      begin
        found = 1'b1;
        sel = 3'(i);
      end
    end
  end

  // Lines switched off are drained and their characters dropped
  always_comb
  begin
    for (int i = 0; i < LINES; i++)
    begin
      take[i] = rdy[i] && (!rxon[i] || (found && sel == 3'(i)));
    end
  end

  // ----------------------------------------
  // Silo control
  // ----------------------------------------
  assign pop = rd_en && addr == OFF_RXBUF && r.count != 7'h00;
  assign store = found && r.count != SILO_FULL;
  assign ovr = found && r.count == SILO_FULL;

  // Next state of silo, registers and pin stages
  always_comb
  begin
    n = r;
    n.s1 = {loop_jumper_pin, ri_pin, cd_pin, rx_pin};
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.filt = (r.s3 & agree) | (r.filt & ~agree);
    n.rd_data = 32'h0;
    if (store)
    begin
      n.silo[r.wptr] = '{ovr: r.ovr_pend, frm: ch_frm[sel], par: ch_par[sel],
        line: sel, data: ch_data[sel]};
      n.wptr = r.wptr + 6'h01;
      n.ovr_pend = 1'b0;
    end
    if (ovr)
    begin
      // The lost character is flagged on the one stored after it
      n.ovr_pend = 1'b1;
      n.stat[IRQ_OVR] = 1'b1;
    end
    if (pop)
    begin
      n.rptr = r.rptr + 6'h01;
      n.alarm = 1'b0;
    end
    n.count = r.count + {6'h00, store} - {6'h00, pop};
    // A read in the same cycle keeps the count at fifteen, so no alarm
    if (store && !pop && r.count == ALARM_PRE)
    begin
      n.alarm = 1'b1;
    end
    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    if (wr_en)
    begin
      unique case (addr)
        OFF_CTRL:
        begin
          n.clr = wr_data[CTRL_CLR];
          n.receive_interrupt_enable = wr_data[CTRL_RIE];
          n.silo_alarm_enable = wr_data[CTRL_SAE];
        end
        OFF_LPR:
        begin
          if (32'(wr_data[LP_LINE +: 3]) < LINES)
          begin
            n.lp[wr_data[LP_LINE +: 3]] = wr_data[LP_FIELD +: LP_W];
          end
        end
        OFF_DTR:
        begin
          n.dtr = wr_data[LINES-1:0];
        end
        OFF_STAT:
        begin
          n.stat = r.stat & ~wr_data[1:0];
        end
        OFF_MASK:
        begin
          n.mask = wr_data[1:0];
        end
        default:
        begin
        end
      endcase
    end
    // Set after the clear so an event in the clearing cycle survives
    if (ovr)
    begin
      n.stat[IRQ_OVR] = 1'b1;
    end
    if (store && r.receive_interrupt_enable && (!r.silo_alarm_enable || (r.count == ALARM_PRE && !pop)))
    begin
      n.stat[IRQ_RX] = 1'b1;
    end
    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    if (rd_en)
    begin
      unique case (addr)
        OFF_CTRL:
        begin
          n.rd_data[CTRL_CLR] = r.clr;
          n.rd_data[CTRL_RIE] = r.receive_interrupt_enable;
          n.rd_data[CTRL_SAE] = r.silo_alarm_enable;
          n.rd_data[CTRL_ALARM] = r.alarm;
        end
        OFF_RXBUF:
        begin
          if (pop)
          begin
            n.rd_data[RB_VALID] = 1'b1;
            // Flags sit in 14:12, bit 11 stays spare
            n.rd_data[14:0] = {r.silo[r.rptr][13:11], 1'b0, r.silo[r.rptr][10:0]};
          end
        end
        OFF_DTR:
        begin
          n.rd_data[LINES-1:0] = r.dtr;
        end
        OFF_MODEM:
        begin
          n.rd_data[LINES-1:0] = car;
          n.rd_data[LINES+15:16] = ring;
        end
        OFF_STAT:
        begin
          n.rd_data[1:0] = r.stat;
        end
        OFF_MASK:
        begin
          n.rd_data[1:0] = r.mask;
        end
        OFF_COUNT:
        begin
          n.rd_data[6:0] = r.count;
        end
        default:
        begin
        end
      endcase
    end
    // Clear command acts one cycle after its write and then drops itself
    if (r.clr)
    begin
      n.clr = 1'b0;
      n.wptr = 6'h00;
      n.rptr = 6'h00;
      n.count = 7'h00;
      n.alarm = 1'b0;
      n.ovr_pend = 1'b0;
      n.receive_interrupt_enable = 1'b0;
      n.silo_alarm_enable = 1'b0;
    end
    n.irq = |(n.stat & n.mask);
  end

  // Whole state in one register, frozen while the enable is low
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      r <= '0;
    end
    else if (ce)
    begin
      r <= n;
    end
  end

  assign rd_data = r.rd_data;
  assign dtr_pin = r.dtr;
  assign irq = r.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_clr_cmd;
    ce && wr_en && addr == OFF_CTRL && wr_data[CTRL_CLR];
  endsequence
  sequence s_clr_exec;
    ce && r.clr;
  endsequence
  sequence s_silo_empty;
    r.count == 7'h00 && !r.clr && !r.alarm && !r.ovr_pend;
  endsequence

  a_alarm_below_16: assert property (r.count < ALARM_LEVEL |-> !r.alarm)
    else $error("alarm set below sixteen characters");
  a_alarm_at_16: assert property (ce && store && !pop && !r.clr && r.count == ALARM_PRE
    |=> r.alarm && r.count == ALARM_LEVEL)
    else $error("alarm missed on sixteenth character");
  a_overrun_pend: assert property (ce && ovr && !r.clr |=> r.ovr_pend && r.stat[IRQ_OVR])
    else $error("overrun not recorded");
  a_overrun_tag: assert property (ce && store && r.ovr_pend && !r.clr
    |=> r.silo[$past(r.wptr)].ovr)
    else $error("overrun not carried by next character");
  a_no_char_irq: assert property (ce && store && r.receive_interrupt_enable && r.silo_alarm_enable && r.count != ALARM_PRE
    && !r.clr && !wr_en |=> r.stat[IRQ_RX] == $past(r.stat[IRQ_RX]))
    else $error("per-character interrupt with alarm enabled");
  a_irq_on_alarm: assert property (ce && store && !pop && r.receive_interrupt_enable && r.silo_alarm_enable && r.count == ALARM_PRE
    && !r.clr |=> r.stat[IRQ_RX] && (r.irq || !r.mask[IRQ_RX]))
    else $error("no interrupt at silo alarm");
  a_irq_level: assert property (r.irq == |(r.stat & r.mask))
    else $error("interrupt output disagrees with status");
  a_clear_empty: assert property (s_clr_cmd ##1 s_clr_exec |=> s_silo_empty)
    else $error("clear command left silo state");
  a_loop_modem: assert property (ce && rd_en && addr == OFF_MODEM && jumper
    |=> r.rd_data[LINES-1:0] == $past(r.dtr) && r.rd_data[LINES+15:16] == $past(r.dtr))
    else $error("loopback carrier or ring wrong");
  a_entry_line: assert property (ce && store && !r.clr
    |=> r.silo[$past(r.wptr)].line == $past(sel) && r.silo[$past(r.wptr)].data == $past(ch_data[sel]))
    else $error("silo entry lost its line");
  a_store_rxon: assert property (store |-> rxon[sel])
    else $error("character stored from disabled line");
  a_read_window: assert property ($past(ce) && !$past(rd_en) |-> r.rd_data == 32'h0)
    else $error("read data outside answer cycle");
endmodule : mars_silo

// [core/mars_pkg.sv]
package mars_pkg;
  // ----------------------------------------
  // Silo geometry
  // ----------------------------------------
  localparam int SILO_DEPTH = 64;
  localparam logic [6:0] SILO_FULL = 7'h40;
  localparam logic [6:0] ALARM_LEVEL = 7'h10;
  localparam logic [6:0] ALARM_PRE = 7'h0f;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RXBUF = 8'h04;
  localparam logic [7:0] OFF_LPR = 8'h08;
  localparam logic [7:0] OFF_DTR = 8'h0c;
  localparam logic [7:0] OFF_MODEM = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_MASK = 8'h18;
  localparam logic [7:0] OFF_COUNT = 8'h1c;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_CLR = 0;
  localparam int CTRL_RIE = 1;
  localparam int CTRL_SAE = 2;
  localparam int CTRL_ALARM = 8;
  localparam int RB_VALID = 15;
  localparam int LP_LINE = 0;
  localparam int LP_FIELD = 3;
  localparam int LP_W = 10;
  localparam int IRQ_RX = 0;
  localparam int IRQ_OVR = 1;
  localparam logic [LP_W-1:0] LP_RST = 10'h000;
  // ----------------------------------------
  // Line rates, tenths of a baud
  // ----------------------------------------
  localparam int BAUD_X10 [16] = '{500, 750, 1100, 1345, 1500, 3000, 6000, 12000,
    18000, 20000, 24000, 36000, 48000, 72000, 96000, 192000};
  typedef struct packed {
    logic ovr;
    logic frm;
    logic par;
    logic [2:0] line;
    logic [7:0] data;
  } mars_entry_t;
  // Bit period in clocks for each rate select
  function automatic logic [16*24-1:0] mars_div_table(longint clk_hz);
    logic [16*24-1:0] t;
    t = '0;
    for (int i = 0; i < 16; i++)
    begin
      t[i*24 +: 24] = 24'(clk_hz * 10 / BAUD_X10[i]);
    end
    return t;
  endfunction : mars_div_table
endpackage : mars_pkg

// [core/mars_line_if.sv]
interface mars_line_if;
  logic rx_level;
  logic [9:0] param;
  logic take;
  logic ready;
  logic [7:0] data;
  logic frm_err;
  logic parity_error_flag;
  modport rx (input rx_level, param, take, output ready, data, frm_err, parity_error_flag);
  modport silo (output rx_level, param, take, input ready, data, frm_err, parity_error_flag);
endinterface : mars_line_if

// [core/mars_line_rx.sv]
module mars_line_rx
  import mars_pkg::*;
#(
  parameter longint CLK_HZ = 200_000_000
)
(
  // Clock and control
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Silo side
  mars_line_if.rx lif
);
  localparam logic [16*24-1:0] DIVS = mars_div_table(CLK_HZ);
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} mars_rx_st_t;
  typedef struct packed {
    mars_rx_st_t st;
    logic [23:0] cnt;
    logic [2:0] bitn;
    logic [7:0] shreg;
    logic par;
    logic pe;
    logic prev;
    logic ready;
    logic [7:0] data;
    logic frm;
    logic pe_out;
  } mars_rx_state_t;
  mars_rx_state_t r, n;
  logic [23:0] div;
  logic [2:0] last;

  // ----------------------------------------
  // Character framing
  // ----------------------------------------
  assign div = DIVS[lif.param[8:5]*24 +: 24];
  assign last = 3'h4 + {1'b0, lif.param[1:0]};

  // One frame per line; each line owns its own copy and format
  always_comb
  begin
    n = r;
    n.prev = lif.rx_level;
    if (lif.take)
    begin
      n.ready = 1'b0;
    end
    if (r.cnt != 24'h0)
    begin
      n.cnt = r.cnt - 24'h1;
    end
    unique case (r.st)
      RX_IDLE:
      begin
        // Falling edge only, so a held break is not re-read as starts
        if (lif.param[9] && r.prev && !lif.rx_level)
        begin
          n.st = RX_START;
          n.cnt = {1'b0, div[23:1]};
        end
      end
      RX_START:
      begin
        if (r.cnt == 24'h0)
        begin
          n.st = lif.rx_level ? RX_IDLE : RX_DATA;
          n.cnt = div - 24'h1;
          n.bitn = 3'h0;
          n.par = 1'b0;
          n.pe = 1'b0;
        end
      end
      RX_DATA:
      begin
        if (r.cnt == 24'h0)
        begin
          n.shreg = {lif.rx_level, r.shreg[7:1]};
          n.par = r.par ^ lif.rx_level;
          n.bitn = r.bitn + 3'h1;
          n.cnt = div - 24'h1;
          if (r.bitn == last)
          begin
            n.st = lif.param[3] ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR:
      begin
        if (r.cnt == 24'h0)
        begin
          n.pe = (r.par ^ lif.rx_level) != lif.param[4];
          n.cnt = div - 24'h1;
          n.st = RX_STOP;
        end
      end
      RX_STOP:
      begin
        // Only the first stop bit is checked, so two stops never slow the receiver
        if (r.cnt == 24'h0)
        begin
          n.ready = 1'b1;
          n.data = r.shreg >> (2'h3 - lif.param[1:0]);
          n.frm = !lif.rx_level;
          n.pe_out = r.pe;
          n.st = RX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      r <= '0;
    end
    else if (ce)
    begin
      r <= n;
    end
  end

  assign lif.ready = r.ready;
  assign lif.data = r.data;
  assign lif.frm_err = r.frm;
  assign lif.parity_error_flag = r.pe_out;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_parity_sense: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ce && r.st == RX_PAR && r.cnt == 24'h0 |=> r.pe == ($past(r.par ^ lif.rx_level) != $past(lif.param[4])))
    else $error("parity flag does not match sense");
  a_rx_off_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    r.st == RX_IDLE && !lif.param[9] |=> r.st == RX_IDLE)
    else $error("start taken with receiver off");
endmodule : mars_line_rx

// [verif/mars_term_model.sv]
module mars_term_model
#(
  parameter int LINES = 8
)
(
  // Clock
  input wire logic ref_clk,
  // Frame request from the bench
  input wire logic go,
  input wire logic [LINES-1:0] line_mask,
  input wire logic [7:0] data,
  input wire logic [1:0] len,
  input wire logic two_stop,
  input wire logic par_en,
  input wire logic [LINES-1:0] odd_mask,
  input wire logic [LINES-1:0] bad_par,
  input wire logic [LINES-1:0] bad_stop,
  input wire logic [31:0] period,
  // Serial side
  output logic [LINES-1:0] rx_pin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] frame [LINES];
  int nb;
  // ----------------------------------------
  // Terminals sending one frame per request
  // ----------------------------------------
  // Idle lines mark high; all selected lines start on the same edge
  initial
  begin
    rx_pin = '1;
    busy = 1'b0;
    forever
    begin
      @(posedge ref_clk);
      if (go)
      begin
        nb = 7 + len + par_en + two_stop;
        for (int l = 0; l < LINES; l++)
        begin
          frame[l] = '1;
          frame[l][0] = 1'b0;
          for (int b = 0; b < 5 + len; b++)
            frame[l][1 + b] = data[b];
          if (par_en)
            frame[l][6 + len] = (^(data & (8'hff >> (2'd3 - len)))) ^ odd_mask[l] ^ bad_par[l];
          frame[l][6 + len + par_en] = ~bad_stop[l];
        end
        busy <= 1'b1;
        for (int b = 0; b < nb; b++)
        begin
          for (int l = 0; l < LINES; l++)
            if (line_mask[l])
              rx_pin[l] <= frame[l][b];
          repeat (period) @(posedge ref_clk);
        end
        // Two idle bits so a bad stop never merges into the next start
        rx_pin <= '1;
        repeat (2 * period) @(posedge ref_clk);
        busy <= 1'b0;
      end
    end
  end
endmodule : mars_term_model

// [verif/test_multiline_async_receive_silo.sv]
module test_multiline_async_receive_silo import mars_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam longint HZ = 96000;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rd_data;
  logic [7:0] rx_pin;
  logic [7:0] dtr_pin;
  logic [7:0] cd_pin = 8'h00;
  logic [7:0] ri_pin = 8'h00;
  logic loop_jumper_pin = 1'b0;
  logic irq;
  logic go = 1'b0;
  logic [7:0] lmask = 8'h00;
  logic [7:0] tdata = 8'h00;
  logic [1:0] tlen = 2'd3;
  logic two = 1'b0;
  logic pen = 1'b0;
  logic [7:0] odd = 8'h00;
  logic [7:0] bpar = 8'h00;
  logic [7:0] bstop = 8'h00;
  int per = 5;
  logic busy;
  int err_total = 0;
  int samples_checked = 0;
  logic [31:0] v;
  logic [7:0] d;
  logic [7:0] od;
  logic [7:0] seen;
  logic [2:0] ln;
  logic [1:0] len;
  logic [3:0] bd;
  logic [7:0] sent [64];
  // Small clock rate keeps the slowest baud frames short
  always #2.5 ref_clk = ~ref_clk;
  mars_silo #(.LINES(8), .CLK_HZ(HZ)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(1'b1), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rx_pin(rx_pin), .cd_pin(cd_pin),
    .ri_pin(ri_pin), .loop_jumper_pin(loop_jumper_pin), .dtr_pin(dtr_pin), .irq(irq));
  mars_term_model #(.LINES(8)) partner (.ref_clk(ref_clk), .go(go), .line_mask(lmask), .data(tdata),
    .len(tlen), .two_stop(two), .par_en(pen), .odd_mask(odd), .bad_par(bpar), .bad_stop(bstop),
    .period(per), .rx_pin(rx_pin), .busy(busy));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic test_done();
    if (err_total == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp);
    samples_checked++;
    if (seen_v !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen_v, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= dv;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] dv);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 dv = rd_data;
  endtask : rd
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    rd(a, x);
    check(x, exp);
  endtask : rdchk
  task automatic wait_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    for (int i = 0; i < 400; i++)
    begin
      rd(a, x);
      if (x === exp)
        return;
    end
    check(x, exp);
    test_done();
  endtask : wait_reg
  task automatic send(input logic [7:0] m, input logic [7:0] dv);
    @(posedge ref_clk);
    lmask <= m;
    tdata <= dv;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    for (int i = 0; i < 40000; i++)
    begin
      @(posedge ref_clk);
      if (!busy)
        return;
    end
    check({31'h0, busy}, 32'h0);
    test_done();
  endtask : send
  function automatic logic [31:0] lpr(input logic [2:0] l, input logic [1:0] n, input logic t, input logic p,
    input logic o, input logic [3:0] b);
    return {19'h0, 1'b1, b, o, p, t, n, l};
  endfunction : lpr
  function automatic logic [31:0] ent(input logic [2:0] flags, input logic [2:0] l, input logic [7:0] dv);
    return {16'h0, 1'b1, flags, 1'b0, l, dv};
  endfunction : ent
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    v = $urandom(32'h82ed7c6a);
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rdchk(OFF_CTRL, 32'h0);
    rdchk(OFF_RXBUF, 32'h0);
    rdchk(8'h20, 32'h0);
    // Loopback jumper turns terminal-ready into carrier and ring
    loop_jumper_pin <= 1'b1;
    wr(OFF_DTR, 32'h5a);
    repeat (8) @(posedge ref_clk);
    check({24'h0, dtr_pin}, 32'h5a);
    rdchk(OFF_MODEM, 32'h005a005a);
    loop_jumper_pin <= 1'b0;
    cd_pin <= 8'h81;
    ri_pin <= 8'h24;
    repeat (8) @(posedge ref_clk);
    rdchk(OFF_MODEM, 32'h00240081);
    // Every rate, then every length at the top rate, two stop bits
    for (int s = 0; s < 20; s++)
    begin
      ln = s[2:0];
      bd = 4'(s < 16 ? s : 15);
      len = s < 8 ? 2'd0 : (s < 16 ? 2'($urandom) : s[1:0]);
      d = 8'($urandom);
      per <= int'(HZ * 10 / BAUD_X10[bd]);
      tlen <= len;
      two <= 1'b1;
      wr(OFF_LPR, lpr(ln, len, 1'b1, 1'b0, 1'b0, bd));
      send(8'h01 << ln, d);
      wait_reg(OFF_COUNT, 32'h1);
      rdchk(OFF_RXBUF, ent(3'b000, ln, d & (8'hff >> (2'd3 - len))));
    end
    // All lines at once, opposite parity senses, seeded bad parity and stop
    for (int r = 0; r < 2; r++)
    begin
      od = r ? 8'h55 : 8'haa;
      for (int l = 0; l < 8; l++)
        wr(OFF_LPR, lpr(l[2:0], 2'd2, 1'b0, 1'b1, od[l], 4'hf));
      per <= 5;
      tlen <= 2'd2;
      two <= 1'b0;
      pen <= 1'b1;
      odd <= od;
      bpar <= 8'($urandom);
      bstop <= 8'($urandom);
      d = 8'($urandom);
      send(8'hff, d);
      wait_reg(OFF_COUNT, 32'h8);
      seen = 8'h00;
      for (int k = 0; k < 8; k++)
      begin
        rd(OFF_RXBUF, v);
        ln = v[10:8];
        seen[ln] = 1'b1;
        check(v, ent({1'b0, bstop[ln], bpar[ln]}, ln, d & 8'h7f));
      end
      check({24'h0, seen}, 32'hff);
    end
    // Fill past full with alarm gating the receive interrupt
    pen <= 1'b0;
    bpar <= 8'h00;
    bstop <= 8'h00;
    tlen <= 2'd3;
    wr(OFF_LPR, lpr(3'd0, 2'd3, 1'b0, 1'b0, 1'b0, 4'hf));
    wr(OFF_MASK, 32'h3);
    wr(OFF_CTRL, 32'h6);
    for (int i = 1; i <= 65; i++)
    begin
      d = i == 3 ? 8'h00 : (i == 4 ? 8'hff : 8'($urandom));
      if (i <= 64)
        sent[i - 1] = d;
      send(8'h01, d);
      wait_reg(i > 64 ? OFF_STAT : OFF_COUNT, i > 64 ? 32'h2 : 32'(i));
      rdchk(OFF_CTRL, {23'h0, i >= 16, 8'h06});
      check({31'h0, irq}, {31'h0, i == 16 || i == 65});
      if (i == 16)
        wr(OFF_STAT, 32'h1);
    end
    rdchk(OFF_COUNT, 32'h40);
    wr(OFF_MASK, 32'h1);
    repeat (2) @(posedge ref_clk);
    check({31'h0, irq}, 32'h0);
    wr(OFF_STAT, 32'h2);
    wr(OFF_MASK, 32'h3);
    repeat (2) @(posedge ref_clk);
    check({31'h0, irq}, 32'h0);
    for (int k = 0; k < 64; k++)
      rdchk(OFF_RXBUF, ent(3'b000, 3'd0, sent[k]));
    rdchk(OFF_RXBUF, 32'h0);
    d = 8'($urandom);
    send(8'h01, d);
    wait_reg(OFF_COUNT, 32'h1);
    // Receiver off keeps stored characters, takes no new ones
    wr(OFF_LPR, lpr(3'd0, 2'd3, 1'b0, 1'b0, 1'b0, 4'hf) & ~32'h1000);
    send(8'h01, 8'h3c);
    repeat (40) @(posedge ref_clk);
    rdchk(OFF_COUNT, 32'h1);
    rdchk(OFF_RXBUF, ent(3'b100, 3'd0, d));
    // Clear command empties the silo and drops back to zero
    wr(OFF_LPR, lpr(3'd0, 2'd3, 1'b0, 1'b0, 1'b0, 4'hf));
    send(8'h01, 8'h11);
    send(8'h01, 8'h22);
    wait_reg(OFF_COUNT, 32'h2);
    wr(OFF_CTRL, 32'h1);
    rdchk(OFF_CTRL, 32'h0);
    rdchk(OFF_COUNT, 32'h0);
    rdchk(OFF_RXBUF, 32'h0);
    // Without alarm enable every character raises the receive event
    wr(OFF_STAT, 32'h3);
    wr(OFF_CTRL, 32'h2);
    send(8'h01, 8'h5a);
    wait_reg(OFF_COUNT, 32'h1);
    rdchk(OFF_STAT, 32'h1);
    check({31'h0, irq}, 32'h1);
    test_done();
  end
endmodule : test_multiline_async_receive_silo
